// ---- verilog/uimd_pkg.sv ----
// Shared constants for the serial-port interrupt, buffer, DMA and modem block.
package uimd_pkg;
	localparam int BUF_DEPTH      = 16;
	localparam int TX_WIDTH       = 8;
	localparam int DATA_WIDTH     = 8;
	localparam int OVERSAMPLE     = 16;
	localparam int TIMEOUT_CHARS  = 4;
	// Modem control bit positions.
	localparam int MC_DTR         = 0;
	localparam int MC_RTS         = 1;
	localparam int MC_OUT1        = 2;
	localparam int MC_OUT2        = 3;
	// Interrupt enable bit positions.
	localparam int IE_RX_DATA     = 0;
	localparam int IE_TX_EMPTY    = 1;
	localparam int IE_LINE        = 2;
	localparam int IE_MODEM       = 3;
	localparam int IE_DMA_RX_END  = 6;
	localparam int IE_DMA_TX_END  = 7;
	// Line status bit positions.
	localparam int LS_DATA_READY  = 0;
	localparam int LS_OVERRUN     = 1;
	localparam int LS_PARITY      = 2;
	localparam int LS_FRAMING     = 3;
	localparam int LS_BREAK       = 4;
	localparam int LS_THR_EMPTY   = 5;
	localparam int LS_TX_EMPTY    = 6;
	localparam int LS_BUF_ERROR   = 7;
	// Interrupt identity layout.
	localparam int ID_RX_END      = 4;
	localparam int ID_TX_END      = 5;
	localparam logic [1:0] ID_BUF_ON = 2'h3;
	typedef enum logic [3:0] {
		UIMD_ID_NONE    = 4'b0001,
		UIMD_ID_LINE    = 4'b0110,
		UIMD_ID_RX_DATA = 4'b0100,
		UIMD_ID_TIMEOUT = 4'b1100,
		UIMD_ID_TX_MT   = 4'b0010,
		UIMD_ID_MODEM   = 4'b0000,
		UIMD_ID_DMA_RX  = 4'b1010,
		UIMD_ID_DMA_TX  = 4'b1110
	} uimd_id_t;
	// Receive trigger levels selected by a 2-bit field.
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0E;
	localparam logic [4:0] CAP_SINGLE = 5'h01;
	localparam logic [3:0] MIN_WORD_BITS = 4'h5;
	localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : uimd_pkg

// ---- verilog/uimd_stream_if.sv ----
// Valid/ready word stream between the block's own modules.
`timescale 1ns/1ps
interface uimd_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : uimd_stream_if

// ---- verilog/uimd_fifo.sv ----
// First-in-first-out buffer with a run-time capacity limit and registered head data.
`timescale 1ns/1ps
module uimd_fifo
	import uimd_pkg::*;
#(
	parameter int DEPTH = BUF_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          clk_i,
	input  wire logic          resetn_i,
	input  wire logic          clear_i,
	input  wire logic [CW-1:0] limit_i,
	uimd_stream_if.snk         wr,
	uimd_stream_if.src         rd,
	output logic      [CW-1:0] count_o
);
	localparam int PW = $clog2(DEPTH);
	logic [$bits(wr.data)-1:0] mem [DEPTH];
	logic [$bits(wr.data)-1:0] head;
	logic [$bits(wr.data)-1:0] next_head;
	logic [PW-1:0]             wptr;
	logic [PW-1:0]             rptr;
	logic [PW-1:0]             next_wptr;
	logic [PW-1:0]             next_rptr;
	logic [CW-1:0]             count;
	logic [CW-1:0]             next_count;
	logic                      push;
	logic                      pop;

	assign wr.ready = (count < limit_i);
	assign rd.valid = (count != '0);
	assign rd.data  = head;
	assign count_o  = count;
	assign push     = wr.valid & wr.ready;
	assign pop      = rd.valid & rd.ready;

	always_comb begin
		next_wptr  = clear_i ? '0 : wptr + PW'(push);
		next_rptr  = clear_i ? '0 : rptr + PW'(pop);
		next_count = clear_i ? '0 : count + CW'(push) - CW'(pop);
		// The slot that becomes the head may be the one written this cycle.
		next_head  = (push && wptr == next_rptr) ? wr.data : mem[next_rptr];
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wptr] <= wr.data;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
			head  <= '0;
		end else begin
			wptr  <= next_wptr;
			rptr  <= next_rptr;
			count <= next_count;
			head  <= next_head;
		end
	end
endmodule : uimd_fifo

// ---- verilog/uimd_core.sv ----
// Interrupt priority, holding buffers, DMA requests and modem control of a serial transceiver.
// Behaviour
// - Modem pins active low, register bits positive.
// - No automatic flow control from modem signals.
// - Single word or 16-word buffers, switched by buffer enable.
// - Buffer enable state visible in identity register.
// - Each direction holds seventeen characters total.
// - Transmit entries 8 bits, receive 11 or 10.
// - Six interrupt classes in fixed priority order.
// - Each class has its own enable bit.
// - Request high until source cleared; complement inverse.
// - Modem control bit 3 optionally gates request.
// - Identity register shows highest pending interrupt.
// - Line status interrupt when errored character at head.
// - Single mode: data ready until character read.
// - Buffered mode: data ready at trigger level.
// - Buffered mode: four character idle time timeout.
// - Timeout follows current format and baud rate.
// - Transmit empty interrupt tracks holding empty flag.
// - Modem interrupt on input change, ring rising.
// - DMA end inputs raise interrupts, shown in identity.
// - Single or multiple DMA mode selection.
// - Single mode receive request while data present.
// - Single mode transmit request only when empty.
// - Multiple mode receive request latches until empty.
// - Multiple mode transmit request off full until empty.
// - DMA end bits shown only when enabled.
// - Interrupt enable bit mapping, bits 4-5 unused.
`timescale 1ns/1ps
module uimd_core
	import uimd_pkg::*;
#(
	parameter bit BUFFERS_BUILT = 1'b1,
	parameter bit RX_WIDE       = 1'b1,
	parameter bit GLOBAL_MASK   = 1'b1
) (
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic [3:0]            modem_control_i,
	input  wire logic                  clear_to_send_low_i,
	input  wire logic                  data_set_ready_low_i,
	input  wire logic                  ring_in_low_i,
	input  wire logic                  carrier_in_low_i,
	output logic                       terminal_ready_low_o,
	output logic                       request_to_send_low_o,
	output logic                       out1_low_o,
	output logic                       out2_low_o,
	input  wire logic                  modem_status_read_i,
	output logic [7:0]                 modem_status_o,
	input  wire logic                  buffer_enable_i,
	input  wire logic                  buffer_dma_mode_i,
	input  wire logic                  buffer_dma_end_show_i,
	input  wire logic [1:0]            buffer_trigger_i,
	input  wire logic                  buffer_rx_clear_i,
	input  wire logic                  buffer_tx_clear_i,
	input  wire logic [7:0]            interrupt_enable_i,
	input  wire logic [1:0]            word_length_i,
	input  wire logic                  stop_bits_i,
	input  wire logic                  parity_enable_i,
	input  wire logic [15:0]           divisor_i,
	input  wire logic [3:0]            prescale_i,
	input  wire logic                  tx_write_valid_i,
	input  wire logic [TX_WIDTH-1:0]   tx_write_data_i,
	output logic                       tx_write_ready_o,
	output logic                       tx_shift_valid_o,
	output logic [TX_WIDTH-1:0]        tx_shift_data_o,
	input  wire logic                  tx_shift_ready_i,
	input  wire logic                  tx_shift_busy_i,
	input  wire logic                  rx_char_valid_i,
	input  wire logic [DATA_WIDTH-1:0] rx_char_data_i,
	input  wire logic                  rx_char_parity_err_i,
	input  wire logic                  rx_char_framing_err_i,
	input  wire logic                  rx_char_break_i,
	output logic                       rx_char_ready_o,
	input  wire logic                  rx_read_i,
	output logic [DATA_WIDTH-1:0]      rx_read_data_o,
	input  wire logic                  line_status_read_i,
	output logic [7:0]                 line_status_o,
	output logic [7:0]                 interrupt_identity_o,
	input  wire logic                  dma_rx_end_i,
	input  wire logic                  dma_tx_end_i,
	output logic                       irq_o,
	output logic                       irq_low_o,
	output logic                       rx_dma_req_o,
	output logic                       rx_dma_req_low_o,
	output logic                       tx_dma_req_o,
	output logic                       tx_dma_req_low_o
);
	localparam int CW  = $clog2(BUF_DEPTH + 1);
	localparam int RXE = RX_WIDE ? 3 : 2;
	localparam int RXW = DATA_WIDTH + RXE;
	localparam logic [CW-1:0] FULL_DEPTH = CW'(BUF_DEPTH);

	uimd_stream_if #(.W(TX_WIDTH)) tx_in ();
	uimd_stream_if #(.W(TX_WIDTH)) tx_out ();
	uimd_stream_if #(.W(RXW))      rx_in ();
	uimd_stream_if #(.W(RXW))      rx_out ();

	logic          buffers_on;
	logic          buffers_on_d;
	logic          dma_multi;
	logic [CW-1:0] limit;
	logic [CW-1:0] rx_count;
	logic [CW-1:0] tx_count;
	logic [CW-1:0] trigger;
	logic          rx_push;
	logic          rx_pop;
	logic          rx_empty;
	logic          tx_empty;
	logic          tx_full;

	// The 16-deep store plus the character in the shift register gives 17 per direction.
	assign buffers_on = BUFFERS_BUILT & buffer_enable_i;
	assign limit      = buffers_on ? FULL_DEPTH : CW'(CAP_SINGLE);
	assign dma_multi  = buffers_on & buffer_dma_mode_i;

	always_comb begin
		unique case (buffer_trigger_i)
			2'h0: trigger = CW'(TRIG_L0);
			2'h1: trigger = CW'(TRIG_L1);
			2'h2: trigger = CW'(TRIG_L2);
			2'h3: trigger = CW'(TRIG_L3);
		endcase
	end

	assign tx_in.valid      = tx_write_valid_i;
	assign tx_in.data       = tx_write_data_i;
	assign tx_write_ready_o = tx_in.ready;
	assign tx_shift_valid_o = tx_out.valid;
	assign tx_shift_data_o  = tx_out.data;
	assign tx_out.ready     = tx_shift_ready_i;

	assign rx_in.valid      = rx_char_valid_i;
	assign rx_in.data       = RX_WIDE ? RXW'({rx_char_break_i, rx_char_framing_err_i, rx_char_parity_err_i,
		rx_char_data_i}) : RXW'({rx_char_framing_err_i | rx_char_break_i, rx_char_parity_err_i, rx_char_data_i});
	assign rx_char_ready_o  = rx_in.ready;
	assign rx_out.ready     = rx_read_i;
	assign rx_read_data_o   = rx_out.data[DATA_WIDTH-1:0];

	assign rx_push  = rx_in.valid & rx_in.ready;
	assign rx_pop   = rx_out.valid & rx_out.ready;
	assign rx_empty = (rx_count == '0);
	assign tx_empty = (tx_count == '0);
	assign tx_full  = (tx_count == limit);

	// Switching the buffers on or off flushes both directions, as a mode change would.
	uimd_fifo #(.DEPTH(BUF_DEPTH)) u_tx_fifo (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.clear_i  (buffer_tx_clear_i | (buffers_on ^ buffers_on_d)),
		.limit_i  (limit),
		.wr       (tx_in),
		.rd       (tx_out),
		.count_o  (tx_count)
	);

	uimd_fifo #(.DEPTH(BUF_DEPTH)) u_rx_fifo (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.clear_i  (buffer_rx_clear_i | (buffers_on ^ buffers_on_d)),
		.limit_i  (limit),
		.wr       (rx_in),
		.rd       (rx_out),
		.count_o  (rx_count)
	);

	// Modem inputs: the first stage feeds only the second; the third gives change detection.
	logic [3:0] modem_meta;
	logic [3:0] modem_sync;
	logic [3:0] modem_prev;
	logic [3:0] modem_delta;
	logic [3:0] next_delta;
	logic [3:0] change;

	always_comb begin
		change              = modem_sync ^ modem_prev;
		// Ring counts only when the pin returns high, i.e. its status bit falls.
		change[2]           = modem_sync[2] & ~modem_prev[2];
		next_delta          = (modem_status_read_i ? 4'h0 : modem_delta) | change;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			modem_meta  <= 4'hF;
			modem_sync  <= 4'hF;
			modem_prev  <= 4'hF;
			modem_delta <= 4'h0;
		end else begin
			modem_meta  <= {carrier_in_low_i, ring_in_low_i, data_set_ready_low_i, clear_to_send_low_i};
			modem_sync  <= modem_meta;
			modem_prev  <= modem_sync;
			modem_delta <= next_delta;
		end
	end

	// Receive timeout: a bit-period clock counter and a bit counter up to four characters.
	logic [24:0] bit_period;
	logic [3:0]  char_bits;
	logic [5:0]  timeout_bits;
	logic [24:0] clk_cnt;
	logic [24:0] next_clk_cnt;
	logic [5:0]  bit_cnt;
	logic [5:0]  next_bit_cnt;
	logic        timeout_pend;
	logic        next_timeout_pend;
	logic        expire;
	logic        restart;

	always_comb begin
		bit_period   = 25'(OVERSAMPLE) * (25'(prescale_i) + 25'd1)
			* ((divisor_i == 16'h0000) ? 25'h10000 : 25'(divisor_i));
		char_bits    = 4'd1 + MIN_WORD_BITS + 4'(word_length_i) + 4'(parity_enable_i)
			+ (stop_bits_i ? 4'd2 : 4'd1);
		timeout_bits = 6'(TIMEOUT_CHARS) * 6'(char_bits);
		restart      = rx_push | rx_pop | rx_empty | ~buffers_on;
		expire       = 1'b0;
		next_clk_cnt = clk_cnt;
		next_bit_cnt = bit_cnt;
		if (restart) begin
			next_clk_cnt = '0;
			next_bit_cnt = '0;
		end else if (bit_cnt < timeout_bits) begin
			if (clk_cnt >= bit_period - 25'd1) begin
				next_clk_cnt = '0;
				next_bit_cnt = bit_cnt + 6'd1;
				expire       = (bit_cnt == timeout_bits - 6'd1);
			end else begin
				next_clk_cnt = clk_cnt + 25'd1;
			end
		end
		next_timeout_pend = expire | (timeout_pend & ~rx_pop & buffers_on & ~rx_empty);
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			clk_cnt      <= '0;
			bit_cnt      <= '0;
			timeout_pend <= 1'b0;
		end else begin
			clk_cnt      <= next_clk_cnt;
			bit_cnt      <= next_bit_cnt;
			timeout_pend <= next_timeout_pend;
		end
	end

	// Line status errors are taken from a character only once it is the head entry.
	logic           head_new;
	logic           next_head_new;
	logic [3:0]     line_err;
	logic [3:0]     next_line_err;
	logic [RXE-1:0] head_err;

	assign head_err = rx_out.data[RXW-1:DATA_WIDTH];

	always_comb begin
		next_head_new = rx_pop ? (rx_push | (rx_count > CW'(1))) : (rx_push & rx_empty);
		next_line_err = line_status_read_i ? 4'h0 : line_err;
		if (rx_char_valid_i && !rx_in.ready) begin
			next_line_err[0] = 1'b1;
		end
		if (head_new) begin
			next_line_err[1] = next_line_err[1] | head_err[0];
			next_line_err[2] = next_line_err[2] | head_err[1];
			if (RX_WIDE) begin
				next_line_err[3] = next_line_err[3] | head_err[RXE-1];
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			head_new     <= 1'b0;
			line_err     <= 4'h0;
			buffers_on_d <= 1'b0;
		end else begin
			head_new     <= next_head_new;
			line_err     <= next_line_err;
			buffers_on_d <= buffers_on;
		end
	end

	// Interrupt sources, priority and request.
	logic     src_line;
	logic     src_data;
	logic     src_tx;
	logic     src_modem;
	logic     src_dma_rx;
	logic     src_dma_tx;
	logic     data_level;
	logic     any_pend;
	uimd_id_t next_id;
	logic [7:0] next_identity;
	logic [7:0] next_line_status;
	logic     next_irq;
	logic     irq;

	always_comb begin
		data_level = buffers_on ? (rx_count >= trigger) : ~rx_empty;
		src_line   = interrupt_enable_i[IE_LINE] & (|line_err);
		src_data   = interrupt_enable_i[IE_RX_DATA] & (data_level | timeout_pend);
		src_tx     = interrupt_enable_i[IE_TX_EMPTY] & tx_empty;
		src_modem  = interrupt_enable_i[IE_MODEM] & (|modem_delta);
		src_dma_rx = interrupt_enable_i[IE_DMA_RX_END] & dma_rx_end_i;
		src_dma_tx = interrupt_enable_i[IE_DMA_TX_END] & dma_tx_end_i;
		any_pend   = src_line | src_data | src_tx | src_modem | src_dma_rx | src_dma_tx;
		if (src_line) begin
			next_id = UIMD_ID_LINE;
		end else if (src_data) begin
			next_id = (timeout_pend && !data_level) ? UIMD_ID_TIMEOUT : UIMD_ID_RX_DATA;
		end else if (src_tx) begin
			next_id = UIMD_ID_TX_MT;
		end else if (src_modem) begin
			next_id = UIMD_ID_MODEM;
		end else if (src_dma_rx) begin
			next_id = UIMD_ID_DMA_RX;
		end else if (src_dma_tx) begin
			next_id = UIMD_ID_DMA_TX;
		end else begin
			next_id = UIMD_ID_NONE;
		end
		next_identity             = {4'h0, next_id};
		next_identity[7:6]        = buffers_on ? ID_BUF_ON : 2'h0;
		next_identity[ID_RX_END]  = buffer_dma_end_show_i & dma_rx_end_i;
		next_identity[ID_TX_END]  = buffer_dma_end_show_i & dma_tx_end_i;
		next_irq = any_pend & (GLOBAL_MASK ? modem_control_i[MC_OUT2] : 1'b1);
		next_line_status                = RESET_BYTE;
		next_line_status[LS_DATA_READY] = ~rx_empty;
		next_line_status[LS_OVERRUN]    = line_err[0];
		next_line_status[LS_PARITY]     = line_err[1];
		next_line_status[LS_FRAMING]    = line_err[2];
		next_line_status[LS_BREAK]      = line_err[3];
		next_line_status[LS_THR_EMPTY]  = tx_empty;
		next_line_status[LS_TX_EMPTY]   = tx_empty & ~tx_shift_busy_i;
		next_line_status[LS_BUF_ERROR]  = buffers_on & (|line_err[3:1]);
	end

	// DMA request state for the multiple-transfer mode.
	logic rx_dma_latch;
	logic next_rx_dma_latch;
	logic tx_dma_latch;
	logic next_tx_dma_latch;

	always_comb begin
		next_rx_dma_latch = ((rx_count >= trigger) | timeout_pend) | (rx_dma_latch & ~rx_empty);
		next_tx_dma_latch = tx_empty | (tx_dma_latch & ~tx_full);
		rx_dma_req_o      = dma_multi ? rx_dma_latch : ~rx_empty;
		tx_dma_req_o      = dma_multi ? (tx_dma_latch & ~tx_full) : tx_empty;
		rx_dma_req_low_o  = ~rx_dma_req_o;
		tx_dma_req_low_o  = ~tx_dma_req_o;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_dma_latch          <= 1'b0;
			tx_dma_latch          <= 1'b1;
			irq                   <= 1'b0;
			interrupt_identity_o  <= {4'h0, UIMD_ID_NONE};
			line_status_o         <= RESET_BYTE;
			modem_status_o        <= RESET_BYTE;
			terminal_ready_low_o  <= 1'b1;
			request_to_send_low_o <= 1'b1;
			out1_low_o            <= 1'b1;
			out2_low_o            <= 1'b1;
		end else begin
			rx_dma_latch          <= next_rx_dma_latch;
			tx_dma_latch          <= next_tx_dma_latch;
			irq                   <= next_irq;
			interrupt_identity_o  <= next_identity;
			line_status_o         <= next_line_status;
			// Status bits are the inverse of the pins; elsewhere the change bits feed only the modem interrupt and OUT2 gates the request.
			modem_status_o        <= {~modem_sync, modem_delta};
			terminal_ready_low_o  <= ~modem_control_i[MC_DTR];
			request_to_send_low_o <= ~modem_control_i[MC_RTS];
			out1_low_o            <= ~modem_control_i[MC_OUT1];
			out2_low_o            <= ~modem_control_i[MC_OUT2];
		end
	end

	assign irq_o     = irq;
	assign irq_low_o = ~irq;
endmodule : uimd_core

// ---- tb/uimd_core_monitor.sv ----
// Concurrent checks on the ports of the serial core.
`timescale 1ns/1ps
module uimd_core_monitor (
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic [3:0] modem_control_i,
	input wire logic       terminal_ready_low_o,
	input wire logic       request_to_send_low_o,
	input wire logic       out1_low_o,
	input wire logic       out2_low_o,
	input wire logic [7:0] modem_status_o,
	input wire logic       modem_status_read_i,
	input wire logic [7:0] interrupt_enable_i,
	input wire logic       buffer_enable_i,
	input wire logic       buffer_dma_end_show_i,
	input wire logic       tx_write_ready_o,
	input wire logic [7:0] line_status_o,
	input wire logic       line_status_read_i,
	input wire logic [7:0] interrupt_identity_o,
	input wire logic       irq_o,
	input wire logic       irq_low_o,
	input wire logic       rx_dma_req_o,
	input wire logic       rx_dma_req_low_o,
	input wire logic       tx_dma_req_o,
	input wire logic       tx_dma_req_low_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	a_pin_inverse: assert property ({irq_low_o, rx_dma_req_low_o, tx_dma_req_low_o} ==
		~{irq_o, rx_dma_req_o, tx_dma_req_o}) else $error("complement output differs");
	a_modem_pins: assert property ($past(resetn_i) |-> {out2_low_o, out1_low_o, request_to_send_low_o,
		terminal_ready_low_o} == ~$past(modem_control_i)) else $error("modem output level wrong");
	a_global_mask: assert property ($past(resetn_i) && !$past(modem_control_i[3]) |-> !irq_o)
		else $error("request while globally masked");
	a_enables_off: assert property ($past(resetn_i) && ($past(interrupt_enable_i) & 8'hCF) == 8'h00
		|-> !irq_o) else $error("request with classes disabled");
	a_tx_full_off: assert property (!tx_write_ready_o |-> !tx_dma_req_o)
		else $error("transmit request while buffer full");
	a_buf_shown: assert property ($past(resetn_i, 2) && $past(buffer_enable_i, 2) == $past(buffer_enable_i)
		|-> interrupt_identity_o[7:6] == {2{$past(buffer_enable_i)}}) else $error("buffer state not shown");
	a_ends_hidden: assert property (!$past(buffer_dma_end_show_i) && !$past(buffer_dma_end_show_i, 2)
		|-> interrupt_identity_o[5:4] == 2'h0) else $error("end bits shown while hidden");
	a_none_quiet: assert property (interrupt_identity_o[0] |-> !irq_o)
		else $error("request with nothing pending");
	a_modem_irq: assert property ((|modem_status_o[3:0]) && interrupt_enable_i[3] && modem_control_i[3]
		&& !modem_status_read_i && !$past(modem_status_read_i) |=> irq_o) else $error("modem change not raised");
	a_line_irq: assert property ((|line_status_o[4:1]) && interrupt_enable_i[2] && modem_control_i[3]
		&& !line_status_read_i && !$past(line_status_read_i) |=> irq_o) else $error("line error not raised");
	c_irq: cover property ($rose(irq_o));
	c_tx_full: cover property (!tx_write_ready_o && buffer_enable_i);
	c_modem_delta: cover property (|modem_status_o[3:0]);
endmodule : uimd_core_monitor

bind uimd_core uimd_core_monitor u_uimd_core_monitor (.*);

// ---- tb/uimd_far_model.sv ----
// Far side stand-in: modem pins and the transmit shift register that drains the buffer.
`timescale 1ns/1ps
module uimd_far_model (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic [3:0] modem_state_i,
	input  wire logic       stall_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	output logic            tx_busy_o,
	output logic [7:0]      tx_last_o,
	output logic [3:0]      pins_low_o
);
	logic [2:0] busy_cnt;
	assign pins_low_o = ~modem_state_i;
	// Four busy cycles a character, so a full buffer drains slowly.
	assign tx_ready_o = !stall_i && busy_cnt == 3'h0;
	assign tx_busy_o  = busy_cnt != 3'h0;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_cnt  <= 3'h0;
			tx_last_o <= 8'h00;
		end else if (tx_valid_i && tx_ready_o) begin
			busy_cnt  <= 3'h4;
			tx_last_o <= tx_data_i;
		end else if (busy_cnt != 3'h0) begin
			busy_cnt <= busy_cnt - 3'h1;
		end
	end
endmodule : uimd_far_model

// ---- tb/uimd_core_tb.sv ----
// Self-checking bench for the interrupt, buffer, DMA and modem core.
`timescale 1ns/1ps
module uimd_core_tb;
	logic clk_i = 1'h0, resetn_i = 1'h0, modem_status_read_i = 1'h0, buffer_enable_i = 1'h0;
	logic buffer_dma_mode_i = 1'h0, buffer_dma_end_show_i = 1'h0, buffer_rx_clear_i = 1'h0;
	logic buffer_tx_clear_i = 1'h0, stop_bits_i = 1'h0, parity_enable_i = 1'h0, tx_write_valid_i = 1'h0;
	logic rx_char_valid_i = 1'h0, rx_char_parity_err_i = 1'h0, rx_char_framing_err_i = 1'h0;
	logic rx_char_break_i = 1'h0, rx_read_i = 1'h0, line_status_read_i = 1'h0, dma_rx_end_i = 1'h0;
	logic dma_tx_end_i = 1'h0, stall = 1'h1;
	logic [1:0] buffer_trigger_i = 2'h0, word_length_i = 2'h3;
	logic [3:0] modem_control_i = 4'h0, prescale_i = 4'h0, ms = 4'h0, pins;
	logic [7:0] interrupt_enable_i = 8'h00, tx_write_data_i = 8'h00, rx_char_data_i = 8'h00, b, last;
	logic [15:0] divisor_i = 16'h0001;
	logic [31:0] seed = 32'h0000_B12E;
	logic clear_to_send_low_i, data_set_ready_low_i, ring_in_low_i, carrier_in_low_i, tx_shift_ready_i;
	logic tx_shift_busy_i, terminal_ready_low_o, request_to_send_low_o, out1_low_o, out2_low_o;
	logic tx_write_ready_o, tx_shift_valid_o, rx_char_ready_o, irq_o, irq_low_o, rx_dma_req_o;
	logic rx_dma_req_low_o, tx_dma_req_o, tx_dma_req_low_o;
	logic [7:0] modem_status_o, tx_shift_data_o, rx_read_data_o, line_status_o, interrupt_identity_o, q[$];
	int err_total = 0, comparisons = 0, cycles = 0;
	always #2 clk_i = ~clk_i;
	uimd_core u_uimd_core (.*);
	uimd_far_model u_uimd_far_model (.clk_i(clk_i), .resetn_i(resetn_i), .modem_state_i(ms), .stall_i(stall),
		.tx_valid_i(tx_shift_valid_o), .tx_data_i(tx_shift_data_o), .tx_ready_o(tx_shift_ready_i),
		.tx_busy_o(tx_shift_busy_i), .tx_last_o(last), .pins_low_o(pins));
	assign {carrier_in_low_i, ring_in_low_i, data_set_ready_low_i, clear_to_send_low_i} = pins;
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	function automatic logic [7:0] ident(input logic [3:0] c);
		return {{2{buffer_enable_i}}, 2'h0, c};
	endfunction : ident
	function automatic int lvl(input logic [1:0] t);
		return (t == 2'h0) ? 1 : (t == 2'h1) ? 4 : (t == 2'h2) ? 8 : 14;
	endfunction : lvl
	task automatic stop_test();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc
	task automatic rx_push(input int n, input logic [2:0] e);
		rx_char_valid_i = 1'h1;
		{rx_char_break_i, rx_char_framing_err_i, rx_char_parity_err_i} = e;
		repeat (n) begin
			rx_char_data_i = xs();
			q.push_back(rx_char_data_i);
			while (!rx_char_ready_o) cyc(1);
			cyc(1);
		end
		rx_char_valid_i = 1'h0;
	endtask : rx_push
	task automatic tx_push(input int n);
		tx_write_valid_i = 1'h1;
		repeat (n) begin
			b = xs();
			tx_write_data_i = b;
			while (!tx_write_ready_o) cyc(1);
			cyc(1);
		end
		tx_write_valid_i = 1'h0;
	endtask : tx_push
	task automatic pop();
		chk(rx_read_data_o, q.pop_front());
		rx_read_i = 1'h1;
		cyc(1);
		rx_read_i = 1'h0;
		cyc(2);
	endtask : pop
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		cyc(12);
		resetn_i = 1'h1;
		cyc(2);
		chk(interrupt_identity_o, ident(4'h1));
		chk({irq_o, rx_dma_req_o, tx_dma_req_o}, 8'h01);
		repeat (4) begin
			modem_control_i = 4'(xs());
			cyc(2);
			chk({out2_low_o, out1_low_o, request_to_send_low_o, terminal_ready_low_o}, {4'h0, ~modem_control_i});
		end
		modem_control_i = 4'h8;
		ms = 4'h8;
		cyc(4);
		chk(modem_status_o, 8'h88);
		interrupt_enable_i = 8'h08;
		cyc(2);
		chk(irq_o, 8'h01);
		chk(interrupt_identity_o, ident(4'h0));
		modem_status_read_i = 1'h1;
		cyc(1);
		modem_status_read_i = 1'h0;
		cyc(2);
		chk(irq_o, 8'h00);
		ms = 4'hC;
		cyc(4);
		chk(modem_status_o, 8'hC0);
		ms = 4'h8;
		cyc(4);
		chk(modem_status_o, 8'h84);
		interrupt_enable_i = 8'h01;
		rx_push(1, 3'h0);
		cyc(2);
		chk(line_status_o & 8'h01, 8'h01);
		chk({rx_dma_req_o, rx_char_ready_o}, 8'h02);
		chk(interrupt_identity_o, ident(4'h4));
		modem_control_i = 4'h0;
		cyc(2);
		chk(irq_o, 8'h00);
		modem_control_i = 4'h8;
		pop();
		chk({irq_o, rx_dma_req_o}, 8'h00);
		interrupt_enable_i = 8'h05;
		for (int k = 0; k < 3; k++) begin
			rx_push(1, 3'h1 << k);
			cyc(3);
			chk(interrupt_identity_o, ident(4'h6));
			chk(line_status_o & 8'h1E, 8'h04 << k);
			line_status_read_i = 1'h1;
			cyc(1);
			line_status_read_i = 1'h0;
			cyc(2);
			chk(interrupt_identity_o, ident(4'h4));
			pop();
		end
		interrupt_enable_i = 8'h02;
		tx_push(1);
		cyc(2);
		chk({irq_o, tx_dma_req_o}, 8'h00);
		stall = 1'h0;
		cyc(8);
		chk(last, b);
		chk({irq_o, tx_dma_req_o, line_status_o[6:5]}, 8'h0F);
		stall = 1'h1;
		{buffer_enable_i, buffer_dma_mode_i, buffer_trigger_i, interrupt_enable_i} = {4'hD, 8'h01};
		{word_length_i, parity_enable_i, stop_bits_i} = 4'h3;
		cyc(3);
		chk(interrupt_identity_o, ident(4'h1));
		rx_push(lvl(2'h1) - 1, 3'h0);
		cyc(2);
		chk({irq_o, rx_dma_req_o}, 8'h00);
		rx_push(1, 3'h0);
		cyc(2);
		chk(interrupt_identity_o, ident(4'h4));
		chk(rx_dma_req_o, 8'h01);
		repeat (lvl(2'h1) - 1) pop();
		chk({irq_o, rx_dma_req_o}, 8'h01);
		// Nine-bit characters at divisor one time out after 576 cycles.
		cyc(536);
		chk(interrupt_identity_o, ident(4'h1));
		cyc(80);
		chk(interrupt_identity_o, ident(4'hC));
		pop();
		chk(rx_dma_req_o, 8'h00);
		interrupt_enable_i = 8'h00;
		tx_push(16);
		cyc(2);
		chk({tx_write_ready_o, tx_dma_req_o}, 8'h00);
		stall = 1'h0;
		cyc(8);
		chk(tx_dma_req_o, 8'h00);
		cyc(100);
		chk(last, b);
		chk(tx_dma_req_o, 8'h01);
		dma_rx_end_i = 1'h1;
		interrupt_enable_i = 8'h30;
		cyc(2);
		chk(irq_o, 8'h00);
		interrupt_enable_i = 8'hC0;
		cyc(2);
		chk(irq_o, 8'h01);
		chk(interrupt_identity_o, ident(4'hA));
		buffer_dma_end_show_i = 1'h1;
		dma_tx_end_i = 1'h1;
		cyc(2);
		chk(interrupt_identity_o, ident(4'hA) | 8'h30);
		stop_test();
	end
endmodule : uimd_core_tb
